/* File: rtl/calendar_pkg.sv */
// Constants shared by the calendar and alarm register block.
// Assumes one 25 MHz clock and an APB3 master with 32-bit data.
package calendar_pkg;

	////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL      = 8'h00; // Write enable word
	localparam logic [7:0] ADDR_ALARM_CFG = 8'h04; // Alarm configuration
	localparam logic [7:0] ADDR_ALARM_HI  = 8'h08; // Alarm value high word
	localparam logic [7:0] ADDR_ALARM_LO  = 8'h0C; // Alarm value low word
	localparam logic [7:0] ADDR_YEAR      = 8'h10; // Year digits
	localparam logic [7:0] ADDR_MONTH_AND_DAY_BCD     = 8'h14; // Month and day
	localparam logic [7:0] ADDR_WEEKDAY_AND_HOUR_BCD    = 8'h18; // Weekday and hour
	localparam logic [7:0] ADDR_MINSEC    = 8'h1C; // Minutes and seconds
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h20; // Sticky events, read only
	localparam logic [7:0] ADDR_IRQ_CLR   = 8'h24; // Write one to clear
	localparam logic [7:0] ADDR_IRQ_EN    = 8'h28; // Interrupt enables

	////////////////////////////////////////////////////////////////////
	// Field positions and masks
	localparam int         CFG_EN_BIT    = 15; // Alarm enable
	localparam int         CFG_CHIME_BIT = 14; // Chime
	localparam int         CFG_MASK_LSB  = 10; // Interval mask, 4 bits
	localparam int         CFG_PTR_LSB   = 8;  // Window pointer, 2 bits
	localparam logic [7:0] YEAR_MASK     = 8'hFF;
	localparam logic [7:0] MONTH_MASK    = 8'h1F;
	localparam logic [7:0] DAY_MASK      = 8'h3F;
	localparam logic [7:0] WEEKDAY_VALUE_MASK     = 8'h07;
	localparam logic [7:0] HOUR_MASK     = 8'h3F;
	localparam logic [7:0] MINSEC_MASK   = 8'h7F;
	localparam int         IRQ_W         = 2;  // Event count
	localparam int         IRQ_ALARM     = 0;  // Alarm event
	localparam int         IRQ_SECOND    = 1;  // Second elapsed

	////////////////////////////////////////////////////////////////////
	// Window pointer codes
	localparam logic [1:0] PTR_MINSEC = 2'h0;
	localparam logic [1:0] PTR_WKHR   = 2'h1;
	localparam logic [1:0] PTR_MONTH_AND_DAY_BCD  = 2'h2;
	localparam logic [1:0] PTR_NONE   = 2'h3;

	////////////////////////////////////////////////////////////////////
	// Interval mask codes
	typedef enum logic [3:0] {
		MASK_HALF_SEC = 4'h0,
		MASK_SEC      = 4'h1,
		MASK_TEN_SEC  = 4'h2,
		MASK_MIN      = 4'h3,
		MASK_TEN_MIN  = 4'h4,
		MASK_HOUR     = 4'h5,
		MASK_DAY      = 4'h6,
		MASK_WEEK     = 4'h7,
		MASK_MONTH    = 4'h8,
		MASK_YEAR     = 4'h9
	} alarm_mask_t;

	////////////////////////////////////////////////////////////////////
	// Digit limits and values after reset
	localparam logic [7:0] SEC_TOP   = 8'h59;
	localparam logic [7:0] HOUR_TOP  = 8'h23;
	localparam logic [7:0] MONTH_TOP = 8'h12;
	localparam logic [7:0] YEAR_TOP  = 8'h99;
	localparam logic [7:0] WEEKDAY_VALUE_TOP  = 8'h06;
	localparam logic [7:0] BCD_ZERO  = 8'h00;
	localparam logic [7:0] BCD_ONE   = 8'h01;
	localparam logic [7:0] RPT_MAX   = 8'hFF;

	////////////////////////////////////////////////////////////////////
	// Time base
	localparam int HALF_SECOND_NS  = 500_000_000;
	localparam int CLK_PERIOD_NS   = 40;
	localparam int HALF_SEC_CYCLES = HALF_SECOND_NS / CLK_PERIOD_NS;

endpackage

/* File: rtl/calendar_alarm_value_access.sv */
// Calendar, time of day and alarm window registers behind APB.
// Assumes an APB3 master on pclk; all inputs synchronous to pclk.
//
// Operation
// - Pointer picks alarm pair seen through window
// - High word access decrements pointer, stops 00
// - Pointer codes map month/day, weekday/hour, min/sec
// - Repeat count holds further alarm repetitions
// - Each alarm event decrements repeat count
// - Count stops at zero unless chime wraps
// - Year holds two BCD digits
// - Year writes accepted only with write enable
// - Month tens bit 12, ones bits 11-8
// - Day tens bits 5-4, ones bits 3-0
// - Date and hour writes need write enable
// - Weekday three bits 10-8, 0 to 6
// - Hour tens bits 5-4, ones bits 3-0
// - Unused upper bits read zero, ignore writes
// - Hardware updates time, pointer and count
// - Alarm enable clears at count zero, chime off
// - Mask selects alarm interval
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps

module calendar_alarm_value_access #(
	parameter int HALF_SEC_CYCLES = calendar_pkg::HALF_SEC_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             alarm_pulse
);

	////////////////////////////////////////////////////////////////////
	// BCD step: returns carry and next value, wrapping past the top
	function automatic logic [8:0] bcd_step(
		input logic [7:0] v,
		input logic [7:0] top,
		input logic [7:0] bottom
	);
		logic [3:0] tens;
		tens = v[7:4] + 4'h1;
		if (v >= top) begin
			bcd_step = {1'b1, bottom};
		end else if (v[3:0] >= 4'h9) begin
			bcd_step = {1'b0, tens, 4'h0};
		end else begin
			bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// Last day of the month in BCD, leap years every fourth year
	function automatic logic [7:0] month_top(
		input logic [7:0] mth,
		input logic [7:0] yr
	);
		logic [3:0] mod4;
		mod4 = (yr[7:4] << 1) + yr[3:0];
		if (mth == 8'h02) begin
			month_top = (mod4[1:0] == 2'h0) ? 8'h29 : 8'h28;
		end else if (mth == 8'h04 || mth == 8'h06 || mth == 8'h09 || mth == 8'h11) begin
			month_top = 8'h30;
		end else begin
			month_top = 8'h31;
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// State
	localparam int IRQ_W = calendar_pkg::IRQ_W; // Event count, sizes status and enables
	logic             wren_ff;        // Time write enable
	logic             alarm_en_ff;    // Alarm enable bit
	logic             chime_ff;       // Chime setting
	logic [3:0]       mask_ff;        // Alarm interval mask
	logic [1:0]       ptr_ff;         // Alarm window pointer
	logic [7:0]       rpt_ff;         // Alarm repeat count
	logic [7:0]       alarm_hi_ff[3]; // Month, weekday, minute
	logic [7:0]       alarm_lo_ff[3]; // Day, hour, second
	logic [7:0]       year_ff;        // Year digits
	logic [7:0]       month_ff;       // Month digits
	logic [7:0]       day_ff;         // Day digits
	logic [7:0]       weekday_value_ff;        // Weekday value
	logic [7:0]       hour_ff;        // Hour digits
	logic [7:0]       min_ff;         // Minute digits
	logic [7:0]       sec_ff;         // Second digits
	logic [IRQ_W-1:0] stat_ff;        // Sticky events
	logic [IRQ_W-1:0] irq_en_ff;      // Event enables
	logic [31:0]      div_ff;         // Half second divider
	logic             phase_ff;       // Second half of a second
	logic             half_d_ff;      // Delayed half tick
	logic             sec_d_ff;       // Delayed second tick

	////////////////////////////////////////////////////////////////////
	// Bus decode
	wire setup  = psel & ~penable;           // Setup phase
	wire access = psel & penable & pready;   // Completing access
	wire wr     = access & pwrite;           // Write takes effect
	wire rd     = access & ~pwrite;          // Read completes
	wire hit_ctrl = paddr == calendar_pkg::ADDR_CTRL;
	wire hit_cfg  = paddr == calendar_pkg::ADDR_ALARM_CFG;
	wire hit_hi   = paddr == calendar_pkg::ADDR_ALARM_HI;
	wire hit_lo   = paddr == calendar_pkg::ADDR_ALARM_LO;
	wire hit_year = paddr == calendar_pkg::ADDR_YEAR;
	wire hit_md   = paddr == calendar_pkg::ADDR_MONTH_AND_DAY_BCD;
	wire hit_wh   = paddr == calendar_pkg::ADDR_WEEKDAY_AND_HOUR_BCD;
	wire hit_ms   = paddr == calendar_pkg::ADDR_MINSEC;
	wire hit_stat = paddr == calendar_pkg::ADDR_IRQ_STAT;
	wire hit_clr  = paddr == calendar_pkg::ADDR_IRQ_CLR;
	wire hit_ien  = paddr == calendar_pkg::ADDR_IRQ_EN;
	wire mapped   = hit_ctrl | hit_cfg | hit_hi | hit_lo | hit_year | hit_md
		| hit_wh | hit_ms | hit_stat | hit_clr | hit_ien;

	// Gated time writes
	wire wr_time = wr & wren_ff;
	wire wr_year = wr_time & hit_year;
	wire wr_md   = wr_time & hit_md;
	wire wr_wh   = wr_time & hit_wh;
	wire wr_ms   = wr_time & hit_ms;
	wire wr_cfg  = wr & hit_cfg;
	wire hi_touch = access & hit_hi;            // Read or write of high word
	wire wr_win  = wr & (hit_hi | hit_lo) & (ptr_ff != calendar_pkg::PTR_NONE);

	////////////////////////////////////////////////////////////////////
	// Read views
	wire [31:0] cfg_view = {16'h0000, alarm_en_ff, chime_ff, mask_ff, ptr_ff, rpt_ff};
	wire [31:0] hi_view  = (ptr_ff == calendar_pkg::PTR_NONE) ? 32'h0000_0000 :
		{24'h00_0000, alarm_hi_ff[ptr_ff]};
	wire [31:0] lo_view  = (ptr_ff == calendar_pkg::PTR_NONE) ? 32'h0000_0000 :
		{24'h00_0000, alarm_lo_ff[ptr_ff]};
	wire [31:0] year_view = {24'h00_0000, year_ff};
	wire [31:0] md_view   = {16'h0000, 3'h0, month_ff[4:0],
		2'h0, day_ff[5:0]};
	wire [31:0] wh_view   = {16'h0000, 5'h00, weekday_value_ff[2:0],
		2'h0, hour_ff[5:0]};
	wire [31:0] ms_view   = {16'h0000, 1'b0, min_ff[6:0], 1'b0, sec_ff[6:0]};

	// Read multiplexer, if chain
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_mux = {31'h0000_0000, wren_ff};
		end else if (hit_cfg) begin
			rd_mux = cfg_view;
		end else if (hit_hi) begin
			rd_mux = hi_view;
		end else if (hit_lo) begin
			rd_mux = lo_view;
		end else if (hit_year) begin
			rd_mux = year_view;
		end else if (hit_md) begin
			rd_mux = md_view;
		end else if (hit_wh) begin
			rd_mux = wh_view;
		end else if (hit_ms) begin
			rd_mux = ms_view;
		end else if (hit_stat) begin
			rd_mux = {{(32-IRQ_W){1'b0}}, stat_ff};
		end else if (hit_ien) begin
			rd_mux = {{(32-IRQ_W){1'b0}}, irq_en_ff};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Time base: half second enable and second enable
	wire half_tick = div_ff >= (HALF_SEC_CYCLES - 1);
	wire sec_tick  = half_tick & phase_ff;

	// Divider and delayed ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff    <= 32'h0000_0000;
			phase_ff  <= 1'b0;
			half_d_ff <= 1'b0;
			sec_d_ff  <= 1'b0;
		end else begin
			div_ff    <= half_tick ? 32'h0000_0000 : div_ff + 32'h0000_0001;
			phase_ff  <= phase_ff ^ half_tick;
			half_d_ff <= half_tick;
			sec_d_ff  <= sec_tick;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Carry chain through the calendar
	wire [8:0] sec_n  = bcd_step(sec_ff, calendar_pkg::SEC_TOP, calendar_pkg::BCD_ZERO);
	wire [8:0] min_n  = bcd_step(min_ff, calendar_pkg::SEC_TOP, calendar_pkg::BCD_ZERO);
	wire [8:0] hour_n = bcd_step(hour_ff, calendar_pkg::HOUR_TOP, calendar_pkg::BCD_ZERO);
	wire [8:0] day_n  = bcd_step(day_ff, month_top(month_ff, year_ff), calendar_pkg::BCD_ONE);
	wire [8:0] weekday_value_n = bcd_step(weekday_value_ff, calendar_pkg::WEEKDAY_VALUE_TOP, calendar_pkg::BCD_ZERO);
	wire [8:0] mth_n  = bcd_step(month_ff, calendar_pkg::MONTH_TOP, calendar_pkg::BCD_ONE);
	wire [8:0] year_n = bcd_step(year_ff, calendar_pkg::YEAR_TOP, calendar_pkg::BCD_ZERO);
	wire c_min  = sec_tick & sec_n[8];
	wire c_hour = c_min & min_n[8];
	wire c_day  = c_hour & hour_n[8];
	wire c_mth  = c_day & day_n[8];
	wire c_year = c_mth & mth_n[8];

	////////////////////////////////////////////////////////////////////
	// Alarm match, checked the cycle after each tick
	wire m_sec  = sec_ff == alarm_lo_ff[calendar_pkg::PTR_MINSEC];
	wire m_sec1 = sec_ff[3:0] == alarm_lo_ff[calendar_pkg::PTR_MINSEC][3:0];
	wire m_min  = min_ff == alarm_hi_ff[calendar_pkg::PTR_MINSEC];
	wire m_min1 = min_ff[3:0] == alarm_hi_ff[calendar_pkg::PTR_MINSEC][3:0];
	wire m_hour = hour_ff == alarm_lo_ff[calendar_pkg::PTR_WKHR];
	wire m_weekday_value = weekday_value_ff[2:0] == alarm_hi_ff[calendar_pkg::PTR_WKHR][2:0];
	wire m_day  = day_ff == alarm_lo_ff[calendar_pkg::PTR_MONTH_AND_DAY_BCD];
	wire m_mth  = month_ff == alarm_hi_ff[calendar_pkg::PTR_MONTH_AND_DAY_BCD];
	wire m_ms   = m_min & m_sec;
	wire m_hms  = m_hour & m_ms;

	// Interval select
	logic mask_hit;
	always_comb begin
		mask_hit = 1'b0;
		case (calendar_pkg::alarm_mask_t'(mask_ff))
			calendar_pkg::MASK_HALF_SEC: mask_hit = half_d_ff;
			calendar_pkg::MASK_SEC:      mask_hit = sec_d_ff;
			calendar_pkg::MASK_TEN_SEC:  mask_hit = sec_d_ff & m_sec1;
			calendar_pkg::MASK_MIN:      mask_hit = sec_d_ff & m_sec;
			calendar_pkg::MASK_TEN_MIN:  mask_hit = sec_d_ff & m_min1 & m_sec;
			calendar_pkg::MASK_HOUR:     mask_hit = sec_d_ff & m_ms;
			calendar_pkg::MASK_DAY:      mask_hit = sec_d_ff & m_hms;
			calendar_pkg::MASK_WEEK:     mask_hit = sec_d_ff & m_weekday_value & m_hms;
			calendar_pkg::MASK_MONTH:    mask_hit = sec_d_ff & m_day & m_hms;
			calendar_pkg::MASK_YEAR:     mask_hit = sec_d_ff & m_mth & m_day & m_hms;
			default:                     mask_hit = 1'b0;    // Reserved codes
		endcase
	end
	wire alarm_evt = alarm_en_ff & mask_hit;

	////////////////////////////////////////////////////////////////////
	// Next values for the alarm configuration
	wire       rpt_zero = rpt_ff == 8'h00;
	wire [7:0] rpt_dec  = rpt_zero ? (chime_ff ? calendar_pkg::RPT_MAX : rpt_ff)
		: rpt_ff - 8'h01;
	wire       auto_off = alarm_evt & rpt_zero & ~chime_ff;
	wire [1:0] ptr_dec  = (ptr_ff == 2'h0) ? ptr_ff : ptr_ff - 2'h1;

	logic [7:0] nxt_rpt;
	logic [1:0] nxt_ptr;
	logic       nxt_alarm_en;
	always_comb begin
		nxt_rpt      = alarm_evt ? rpt_dec : rpt_ff;
		nxt_ptr      = hi_touch ? ptr_dec : ptr_ff;
		nxt_alarm_en = auto_off ? 1'b0 : alarm_en_ff;
		if (wr_cfg) begin
			nxt_rpt      = pwdata[7:0];
			nxt_ptr      = pwdata[calendar_pkg::CFG_PTR_LSB +: 2];
			nxt_alarm_en = pwdata[calendar_pkg::CFG_EN_BIT];
		end
	end

	// Alarm configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_en_ff <= 1'b0;
			chime_ff    <= 1'b0;
			mask_ff     <= 4'h0;
			ptr_ff      <= 2'h0;
			rpt_ff      <= 8'h00;
		end else begin
			alarm_en_ff <= nxt_alarm_en;
			ptr_ff      <= nxt_ptr;
			rpt_ff      <= nxt_rpt;
			if (wr_cfg) begin
				chime_ff <= pwdata[calendar_pkg::CFG_CHIME_BIT];
				mask_ff  <= pwdata[calendar_pkg::CFG_MASK_LSB +: 4];
			end
		end
	end

	// Alarm value pairs through the window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 3; i++) begin
				alarm_hi_ff[i] <= 8'h00;
				alarm_lo_ff[i] <= 8'h00;
			end
		end else if (wr_win) begin
			if (hit_hi) begin
				alarm_hi_ff[ptr_ff] <= pwdata[7:0];
			end else begin
				alarm_lo_ff[ptr_ff] <= pwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Time and calendar registers; a software write wins over a carry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_ff   <= calendar_pkg::BCD_ZERO;
			min_ff   <= calendar_pkg::BCD_ZERO;
			hour_ff  <= calendar_pkg::BCD_ZERO;
			weekday_value_ff  <= calendar_pkg::BCD_ZERO;
			day_ff   <= calendar_pkg::BCD_ONE;
			month_ff <= calendar_pkg::BCD_ONE;
			year_ff  <= calendar_pkg::BCD_ZERO;
		end else begin
			if (wr_ms) begin
				min_ff <= pwdata[15:8] & calendar_pkg::MINSEC_MASK;
				sec_ff <= pwdata[7:0] & calendar_pkg::MINSEC_MASK;
			end else begin
				if (sec_tick) sec_ff <= sec_n[7:0];
				if (c_min) min_ff <= min_n[7:0];
			end
			if (wr_wh) begin
				weekday_value_ff <= pwdata[15:8] & calendar_pkg::WEEKDAY_VALUE_MASK;
				hour_ff <= pwdata[7:0] & calendar_pkg::HOUR_MASK;
			end else if (c_hour) begin
				hour_ff <= hour_n[7:0];
			end
			if (!wr_wh && c_day) begin
				weekday_value_ff <= weekday_value_n[7:0];
			end
			if (wr_md) begin
				month_ff <= pwdata[15:8] & calendar_pkg::MONTH_MASK;
				day_ff   <= pwdata[7:0] & calendar_pkg::DAY_MASK;
			end else begin
				if (c_day) day_ff <= day_n[7:0];
				if (c_mth) month_ff <= mth_n[7:0];
			end
			if (wr_year) begin
				year_ff <= pwdata[7:0] & calendar_pkg::YEAR_MASK;
			end else if (c_year) begin
				year_ff <= year_n[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control, interrupt status and enables; set wins over clear
	wire [IRQ_W-1:0] evt_set = {sec_tick, alarm_evt};
	wire [IRQ_W-1:0] evt_clr = (wr & hit_clr) ? pwdata[IRQ_W-1:0] : '0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wren_ff   <= 1'b0;
			stat_ff   <= '0;
			irq_en_ff <= '0;
		end else begin
			stat_ff <= (stat_ff & ~evt_clr) | evt_set;
			if (wr & hit_ctrl) wren_ff <= pwdata[0];
			if (wr & hit_ien) irq_en_ff <= pwdata[IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registered outputs: answer in the cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready      <= 1'b0;
			prdata      <= 32'h0000_0000;
			pslverr     <= 1'b0;
			irq         <= 1'b0;
			alarm_pulse <= 1'b0;
		end else begin
			pready      <= setup;
			prdata      <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
			pslverr     <= setup & ~mapped;
			irq         <= |(stat_ff & irq_en_ff);
			alarm_pulse <= alarm_evt;
		end
	end

endmodule

/* File: testbench/calendar_alarm_value_access_assertions.sv */
// Port-level checks for the calendar and alarm window register block.
// Assumes the single pclk domain and an active-low asynchronous presetn.
`timescale 1ns/1ps

module calendar_alarm_value_access_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic        alarm_pulse
);
	////////////////////////////////////////////////////////////////////
	// Aligned word inside the register map
	wire mapped = (paddr[1:0] == 2'b00) && (paddr <= calendar_pkg::ADDR_IRQ_EN);
	// Answered read
	wire rd_ok  = pready && !pwrite;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("ready missing after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_error_on_unmapped: assert property (pready |-> pslverr == !mapped)
		else $error("error flag does not match decode");
	a_idle_data_zero: assert property (!rd_ok |-> prdata == 32'h0000_0000)
		else $error("read data outside a read answer");
	a_upper_half_zero: assert property (rd_ok |-> prdata[31:16] == 16'h0000)
		else $error("upper half of read data not zero");
	a_year_digits: assert property (rd_ok && paddr == calendar_pkg::ADDR_YEAR |->
		prdata[15:8] == 8'h00 && prdata[7:4] <= 4'h9 && prdata[3:0] <= 4'h9)
		else $error("year digits out of range");
	a_date_fields: assert property (rd_ok && paddr == calendar_pkg::ADDR_MONTH_AND_DAY_BCD |->
		prdata[15:13] == 3'h0 && prdata[7:6] == 2'h0 && prdata[11:8] <= 4'h9
		&& prdata[3:0] <= 4'h9)
		else $error("month and day fields malformed");
	a_weekday_value_hour: assert property (rd_ok && paddr == calendar_pkg::ADDR_WEEKDAY_AND_HOUR_BCD |->
		prdata[15:11] == 5'h00 && prdata[10:8] <= 3'h6 && prdata[5:4] <= 2'h2
		&& prdata[3:0] <= 4'h9)
		else $error("weekday and hour fields malformed");
	a_pulse_single: assert property (alarm_pulse |=> !alarm_pulse)
		else $error("alarm pulse longer than one cycle");

	// Main scenarios reached
	c_alarm: cover property (alarm_pulse);
	c_error: cover property (pslverr);
	c_window: cover property (rd_ok && paddr == calendar_pkg::ADDR_ALARM_HI);
	c_irq: cover property ($rose(irq));
endmodule

bind calendar_alarm_value_access calendar_alarm_value_access_assertions chk (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
	.alarm_pulse(alarm_pulse));

/* File: testbench/calendar_alarm_value_access_test.sv */
// Self-checking bench for the calendar and alarm window register block.
// Assumes a half second of 4 cycles, so one second is 8 cycles.
`timescale 1ns/1ps

module calendar_alarm_value_access_test;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, alarm_pulse;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	int          err_total, tests_run, pulses, n;
	logic [31:0] seed, rd, ey, em, ew; // Random state, read data, expected values
	logic        er;                   // Error flag of last transfer
	logic [7:0]  hi_exp [4];           // Expected window bytes by pointer
	logic [7:0]  lo_exp [4];

	calendar_alarm_value_access #(.HALF_SEC_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.alarm_pulse(alarm_pulse));

	////////////////////////////////////////////////////////////////////
	// Clock and alarm pulse counter
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(negedge pclk) begin
		if (alarm_pulse === 1'b1) pulses++;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
	endfunction
	// Value below 100 as two BCD digits
	function automatic logic [7:0] bcd(input int v);
		return 8'((v / 10) * 16 + v % 10);
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// One APB transfer; answer taken at the rising edge that samples pready high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1);
		check(32'(k < 16), 32'h0000_0001, "ready wait");
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp, what);
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		complete_run();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{err_total, tests_run, pulses} = '0;
		seed = 32'h0000_86c7;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdc(calendar_pkg::ADDR_ALARM_CFG, 32'h0000_0000, "cfg reset");
		rdc(calendar_pkg::ADDR_MONTH_AND_DAY_BCD, 32'h0000_0101, "date reset");
		// Writes without write enable are dropped
		apb(1'b1, calendar_pkg::ADDR_YEAR, 32'h0000_0055);
		rdc(calendar_pkg::ADDR_YEAR, 32'h0000_0000, "year locked");
		apb(1'b1, calendar_pkg::ADDR_CTRL, 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			n = int'(seed[15:0]);
			ey = 32'(bcd(n % 100));
			em = 32'({bcd(1 + n % 12), bcd(1 + n % 28)});
			ew = 32'({bcd(n % 7), bcd(n % 24)});
			apb(1'b1, calendar_pkg::ADDR_YEAR, ey | (seed & ~32'h0000_00FF));
			apb(1'b1, calendar_pkg::ADDR_MONTH_AND_DAY_BCD, em | (seed & ~32'h0000_1F3F));
			apb(1'b1, calendar_pkg::ADDR_WEEKDAY_AND_HOUR_BCD, ew | (seed & ~32'h0000_073F));
			rdc(calendar_pkg::ADDR_YEAR, ey, "year");
			rdc(calendar_pkg::ADDR_MONTH_AND_DAY_BCD, em, "month day");
			rdc(calendar_pkg::ADDR_WEEKDAY_AND_HOUR_BCD, ew, "weekday hour");
		end
		apb(1'b1, calendar_pkg::ADDR_CTRL, 32'h0000_0000);
		apb(1'b1, calendar_pkg::ADDR_MONTH_AND_DAY_BCD, 32'h0000_0505);
		apb(1'b1, calendar_pkg::ADDR_WEEKDAY_AND_HOUR_BCD, 32'h0000_0505);
		rdc(calendar_pkg::ADDR_MONTH_AND_DAY_BCD, em, "date locked");
		rdc(calendar_pkg::ADDR_WEEKDAY_AND_HOUR_BCD, ew, "hour locked");
		// Alarm window: fill pairs from pointer 10 down, low word first
		apb(1'b1, calendar_pkg::ADDR_ALARM_CFG, 32'h0000_0200);
		{hi_exp[3], lo_exp[3]} = 16'h0000;
		for (int p = 2; p >= 0; p--) begin
			seed = lfsr(seed);
			hi_exp[p] = (p == 2) ? bcd(1 + seed[15:0] % 12) : (p == 1) ? bcd(seed[15:0] % 7)
				: bcd(seed[15:0] % 60);
			lo_exp[p] = (p == 2) ? bcd(1 + seed[31:16] % 28) : (p == 1) ? bcd(seed[31:16] % 24)
				: bcd(seed[31:16] % 60);
			apb(1'b1, calendar_pkg::ADDR_ALARM_LO, 32'(lo_exp[p]));
			apb(1'b1, calendar_pkg::ADDR_ALARM_HI, 32'(hi_exp[p]));
		end
		rdc(calendar_pkg::ADDR_ALARM_CFG, 32'h0000_0000, "pointer at 00");
		apb(1'b1, calendar_pkg::ADDR_ALARM_CFG, 32'h0000_0300);
		for (int i = 0; i < 5; i++) begin
			n = (i < 4) ? 3 - i : 0;
			rdc(calendar_pkg::ADDR_ALARM_LO, 32'(lo_exp[n]), "window low");
			rdc(calendar_pkg::ADDR_ALARM_HI, 32'(hi_exp[n]), "window high");
		end
		rdc(calendar_pkg::ADDR_ALARM_CFG, 32'h0000_0000, "pointer holds");
		// Half-second alarm, two repeats, no chime
		pulses = 0;
		apb(1'b1, calendar_pkg::ADDR_ALARM_CFG, 32'h0000_8002);
		repeat (40) @(posedge pclk);
		check(32'(pulses), 32'h0000_0003, "alarm events");
		rdc(calendar_pkg::ADDR_ALARM_CFG, 32'h0000_0000, "auto disable");
		// Per-second alarm with chime wraps 00 to FF
		pulses = 0;
		apb(1'b1, calendar_pkg::ADDR_ALARM_CFG, 32'h0000_C401);
		for (int k = 0; k < 100 && pulses < 3; k++) @(negedge pclk);
		rdc(calendar_pkg::ADDR_ALARM_CFG, 32'h0000_C4FE, "chime wrap");
		apb(1'b1, calendar_pkg::ADDR_ALARM_CFG, 32'h0000_0000);
		// Minute alarm fires on the stored second, then turns itself off
		n = pulses;
		apb(1'b1, calendar_pkg::ADDR_ALARM_CFG, 32'h0000_8C00);
		for (int k = 0; k < 600 && pulses == n; k++) @(negedge pclk);
		apb(1'b0, calendar_pkg::ADDR_MINSEC, 32'h0000_0000);
		check(rd & 32'h0000_007F, 32'(lo_exp[0]), "minute alarm second");
		rdc(calendar_pkg::ADDR_ALARM_CFG, 32'h0000_0C00, "minute alarm off");
		// Interrupt masked, enabled, cleared
		check(32'(irq), 32'h0000_0000, "irq masked");
		apb(1'b1, calendar_pkg::ADDR_IRQ_EN, 32'h0000_0001);
		repeat (2) @(negedge pclk);
		check(32'(irq), 32'h0000_0001, "irq raised");
		apb(1'b1, calendar_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
		repeat (2) @(negedge pclk);
		check(32'(irq), 32'h0000_0000, "irq cleared");
		apb(1'b0, calendar_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
		check(rd & 32'h0000_0001, 32'h0000_0000, "status cleared");
		// Unmapped address
		apb(1'b0, 8'h40, 32'h0000_0000);
		check({rd[30:0], er}, 32'h0000_0001, "unmapped read");
		// Full carry from 59:59 at 23h on 31 Dec 99
		apb(1'b1, calendar_pkg::ADDR_CTRL, 32'h0000_0001);
		apb(1'b1, calendar_pkg::ADDR_YEAR, 32'h0000_0099);
		apb(1'b1, calendar_pkg::ADDR_MONTH_AND_DAY_BCD, 32'h0000_1231);
		apb(1'b1, calendar_pkg::ADDR_WEEKDAY_AND_HOUR_BCD, 32'h0000_0623);
		apb(1'b1, calendar_pkg::ADDR_MINSEC, 32'h0000_5959);
		repeat (12) @(posedge pclk);
		rdc(calendar_pkg::ADDR_YEAR, 32'h0000_0000, "year carry");
		rdc(calendar_pkg::ADDR_MONTH_AND_DAY_BCD, 32'h0000_0101, "date carry");
		rdc(calendar_pkg::ADDR_WEEKDAY_AND_HOUR_BCD, 32'h0000_0000, "hour carry");
		complete_run();
	end
endmodule
